// ### inc/sscd_pkg.sv
package sscd_pkg;
   // register addresses of the address-mode map
   localparam logic [6:0] SSCD_ADDR_SW    = 7'h01;
   localparam logic [6:0] SSCD_ADDR_CFG   = 7'h02;
   localparam logic [6:0] SSCD_ADDR_FLAGS = 7'h03;
   localparam logic [6:0] SSCD_ADDR_BURST = 7'h05;
   localparam logic [6:0] SSCD_ADDR_SOFT  = 7'h0B;
   // reset values
   localparam logic [7:0] SSCD_RST_SW     = 8'h00;
   localparam logic [7:0] SSCD_RST_CFG    = 8'h06;
   localparam logic [7:0] SSCD_RST_FLAGS  = 8'h00;
   localparam logic [7:0] SSCD_RST_BURST  = 8'h00;
   localparam logic [7:0] SSCD_RST_SOFT   = 8'h00;
   // writable bits of the switch, configuration and burst registers
   localparam logic [7:0] SSCD_MASK_SW    = 8'h0F;
   localparam logic [7:0] SSCD_MASK_CFG   = 8'h07;
   localparam logic [7:0] SSCD_MASK_BURST = 8'h01;
   // bit positions in the configuration and flag registers
   localparam int SSCD_BIT_CRC  = 0;
   localparam int SSCD_BIT_SCLK = 1;
   localparam int SSCD_BIT_RW   = 2;
   // frame constants
   localparam logic [7:0]  SSCD_ALIGN     = 8'h25;
   localparam logic [15:0] SSCD_CLR_CMD   = 16'h6CA9;
   localparam logic [7:0]  SSCD_CRC_POLY  = 8'h07;
   localparam logic [7:0]  SSCD_CRC_SEED  = 8'h00;
   localparam logic [5:0]  SSCD_CNT_ADDR  = 6'd8;
   localparam logic [5:0]  SSCD_CNT_CHECK = 6'd9;
   localparam logic [5:0]  SSCD_CNT_BASE  = 6'd16;
   localparam logic [5:0]  SSCD_CNT_CRC   = 6'd24;
   localparam logic [5:0]  SSCD_CNT_MAX   = 6'd63;
   // frame tracking states
   typedef enum logic [1:0] {
      SSCD_IDLE  = 2'b01,
      SSCD_FRAME = 2'b10
   } sscd_state_t;
endpackage : sscd_pkg

// ### src/sscd_crc8.sv
`timescale 1ns/100ps
// crc over a 16-bit payload, msb first, result held in a register
module sscd_crc8 (
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        load,
   input  wire logic [15:0] payload,
   output logic      [7:0]  crc_q
);
   import sscd_pkg::*;

   logic [7:0] crc_d;

   // one cycle for the whole word keeps the serial path free of timing
   function automatic logic [7:0] crc_word(input logic [15:0] w);
      logic [7:0] c;
      c = SSCD_CRC_SEED;
      for (int i = 15; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? SSCD_CRC_POLY : 8'h00);
      end
      return c;
   endfunction : crc_word

   always_comb begin
      crc_d = load ? crc_word(payload) : crc_q;
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         crc_q <= SSCD_CRC_SEED;
      end else begin
         crc_q <= crc_d;
      end
   end
endmodule : sscd_crc8

// ### src/sscd_top.sv
`timescale 1ns/100ps
// Notes on behaviour
// - spi modes 0 and 3 both work
// - frame is 16 clocks between cs edges
// - first bit 0 write, 1 read
// - then seven address bits, eight data bits
// - read returns register on sdo, input ignored
// - address taken at eighth rising edge
// - no crc: write at sixteenth rising edge
// - sdo sends 0x25 alignment byte first
// - sample rising, drive falling, open drain
// - crc adds eight clocks, 24 total
// - crc x8+x2+x+1, seed zero, 16 bits
// - bad crc blocks write, sets crc flag
// - host sends crc on writes, device on reads
// - crc checking off after reset, switchable
// - wrong clock count sets clock flag
// - short frame never writes; long still writes
// - clock count check on after reset
// - unknown or read-only address sets address flag
// - address checked at ninth edge, blocks write
// - address check on after reset
// - each error has enable and flag bit
// - clear command empties flags, not address error
// - reset pin low restores defaults, opens switches
module sscd_top (
   input  wire logic       clock,
   input  wire logic       srst,
   input  wire logic       rst_pin_n,
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       sdi,
   output logic            sdo_o,
   output logic            sdo_oe,
   output logic      [3:0] switch_en,
   output logic      [2:0] err_flag
);
   import sscd_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; only the second stage and later are read
   logic [3:0] sync1_q, sync2_q;
   logic       sclk_prev_q, cs_prev_q;
   logic       sclk_s, cs_s, sdi_s, rstp_s;
   assign sclk_s = sync2_q[0];
   assign cs_s   = sync2_q[1];
   assign sdi_s  = sync2_q[2];
   assign rstp_s = sync2_q[3];

   always_ff @(posedge clock) begin
      if (srst) begin
         sync1_q     <= 4'hA;
         sync2_q     <= 4'hA;
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
      end else begin
         sync1_q     <= {rst_pin_n, sdi, cs_n, sclk};
         sync2_q     <= sync1_q;
         sclk_prev_q <= sclk_s;
         cs_prev_q   <= cs_s;
      end
   end

   // the pin reset clears everything that software can see
   logic any_rst;
   assign any_rst = srst | ~rstp_s;

   // edge strobes; sclk edges only count inside a frame, so mode 0 and 3 both fit
   logic rise, fall, cs_fall, cs_rise;
   assign cs_fall = cs_prev_q & ~cs_s;
   assign cs_rise = ~cs_prev_q & cs_s;
   assign rise    = sclk_s & ~sclk_prev_q & ~cs_s;
   assign fall    = ~sclk_s & sclk_prev_q & ~cs_s;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode used at the check edge; the read latch decodes through rd_mux
   function automatic logic addr_known(input logic [6:0] a);
      return (a == SSCD_ADDR_SW) || (a == SSCD_ADDR_CFG) || (a == SSCD_ADDR_FLAGS) ||
             (a == SSCD_ADDR_BURST) || (a == SSCD_ADDR_SOFT);
   endfunction : addr_known

   ////////////////////////////////////////////////////////////////////////////////
   // frame state
   sscd_state_t state_q, state_d;
   logic [5:0]  cnt_q, cnt_d;
   logic [15:0] shift_q, shift_d;
   logic [15:0] cmd_q, cmd_d;
   logic [6:0]  addr_q, addr_d;
   logic        dir_q, dir_d;
   logic        inval_q, inval_d;
   logic [7:0]  rdata_q, rdata_d;
   logic [7:0]  sw_q, sw_d, cfg_q, cfg_d, flags_q, flags_d, burst_q, burst_d;
   logic [7:0]  soft_q, soft_d;
   logic        bit_q, bit_d, oe_q, oe_d;
   logic        crcf_q, crcf_d;                     // crc mode in force when the frame opened
   logic        crc_load;
   logic [15:0] crc_payload;
   logic [7:0]  crc_q;

   logic [7:0]  byte_now, rd_mux;
   logic [15:0] word_now;
   logic        crc_en, at_addr, at_check, at_base, at_crc, crc_ok, commit, clear;
   assign byte_now = {shift_q[6:0], sdi_s};
   assign word_now = {shift_q[14:0], sdi_s};
   assign crc_en   = cfg_q[SSCD_BIT_CRC];
   assign at_addr  = rise && (cnt_q == SSCD_CNT_ADDR - 6'd1);
   assign at_check = rise && (cnt_q == SSCD_CNT_CHECK - 6'd1);
   assign at_base  = rise && (cnt_q == SSCD_CNT_BASE - 6'd1);
   assign at_crc   = rise && (cnt_q == SSCD_CNT_CRC - 6'd1);
   assign crc_ok   = (byte_now == crc_q);
   // short frames never reach these edges, so they can never write
   assign commit   = !dir_q && !inval_q &&
                     (crc_en ? (at_crc && crc_ok) : at_base);
   assign clear    = commit && ((crc_en ? cmd_q : word_now) == SSCD_CLR_CMD);

   // read mux over the live register contents
   always_comb begin
      case (byte_now[6:0])
         SSCD_ADDR_SW:    rd_mux = sw_q;
         SSCD_ADDR_CFG:   rd_mux = cfg_q;
         SSCD_ADDR_FLAGS: rd_mux = flags_q;
         SSCD_ADDR_BURST: rd_mux = burst_q;
         SSCD_ADDR_SOFT:  rd_mux = soft_q;
         default:         rd_mux = 8'h00;
      endcase
   end

   // crc engine: read frames hash the command byte and the read data, write frames the incoming word
   assign crc_load    = (at_addr && byte_now[7]) || (at_base && !dir_q);
   assign crc_payload = at_addr ? {byte_now, rd_mux} : word_now;

   sscd_crc8 u_crc (
      .clock   (clock),
      .srst    (any_rst),
      .load    (crc_load),
      .payload (crc_payload),
      .crc_q   (crc_q)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // next values of the frame and register state
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      cmd_d   = cmd_q;
      addr_d  = addr_q;
      dir_d   = dir_q;
      inval_d = inval_q;
      rdata_d = rdata_q;
      sw_d    = sw_q;
      cfg_d   = cfg_q;
      burst_d = burst_q;
      soft_d  = soft_q;
      flags_d = clear ? SSCD_RST_FLAGS : flags_q;   // sets below win over the clear
      bit_d   = bit_q;
      crcf_d  = crcf_q;
      case (state_q)
         SSCD_IDLE: begin
            if (cs_fall) begin
               state_d = SSCD_FRAME;
               cnt_d   = 6'd0;
               inval_d = 1'b0;
               bit_d   = SSCD_ALIGN[7];
               // a frame that toggles crc must not count itself as wrong length
               crcf_d  = crc_en;
            end
         end
         SSCD_FRAME: begin
            if (cs_rise) begin
               state_d = SSCD_IDLE;
               bit_d   = 1'b1;
               // sclk count check happens only when the frame closes
               if (cfg_q[SSCD_BIT_SCLK] &&
                   cnt_q != (crcf_q ? SSCD_CNT_CRC : SSCD_CNT_BASE)) begin
                  flags_d[SSCD_BIT_SCLK] = 1'b1;
               end
            end
            if (rise) begin
               cnt_d   = (cnt_q == SSCD_CNT_MAX) ? cnt_q : 6'(cnt_q + 6'd1);
               shift_d = word_now;
            end
            if (at_addr) begin
               dir_d   = byte_now[7];
               addr_d  = byte_now[6:0];
               rdata_d = rd_mux;
            end
            if (at_check) begin
               // the clear command address passes here and is judged at edge 16
               if ((!addr_known(addr_q) && addr_q != SSCD_CLR_CMD[14:8]) ||
                   (!dir_q && addr_q == SSCD_ADDR_FLAGS)) begin
                  inval_d = 1'b1;
                  if (cfg_q[SSCD_BIT_RW]) flags_d[SSCD_BIT_RW] = 1'b1;
               end
            end
            if (at_base) begin
               cmd_d = word_now;
               if (addr_q == SSCD_CLR_CMD[14:8] && word_now != SSCD_CLR_CMD) begin
                  inval_d = 1'b1;
                  if (cfg_q[SSCD_BIT_RW]) flags_d[SSCD_BIT_RW] = 1'b1;
               end
            end
            if (at_crc && crc_en && !dir_q && !crc_ok) begin
               flags_d[SSCD_BIT_CRC] = 1'b1;
            end
            if (commit) begin
               case (addr_q)
                  SSCD_ADDR_SW:    sw_d    = byte_now & SSCD_MASK_SW;
                  SSCD_ADDR_CFG:   cfg_d   = (crc_en ? cmd_q[7:0] : byte_now) & SSCD_MASK_CFG;
                  SSCD_ADDR_BURST: burst_d = byte_now & SSCD_MASK_BURST;
                  SSCD_ADDR_SOFT:  soft_d  = byte_now;
                  default:         ;
               endcase
               if (crc_en) begin
                  if (addr_q == SSCD_ADDR_SW) sw_d = cmd_q[7:0] & SSCD_MASK_SW;
                  if (addr_q == SSCD_ADDR_BURST) burst_d = cmd_q[7:0] & SSCD_MASK_BURST;
                  if (addr_q == SSCD_ADDR_SOFT) soft_d = cmd_q[7:0];
               end
            end
            // falling edge k presents frame bit k: alignment, data, then crc
            if (fall && cnt_q != 6'd0) begin
               if (cnt_q < SSCD_CNT_ADDR) begin
                  bit_d = SSCD_ALIGN[~cnt_q[2:0]];
               end else if (cnt_q < SSCD_CNT_BASE) begin
                  bit_d = rdata_q[~cnt_q[2:0]];
               end else if (cnt_q < SSCD_CNT_CRC && crc_en && dir_q) begin
                  bit_d = crc_q[~cnt_q[2:0]];
               end else begin
                  bit_d = 1'b1;
               end
            end
         end
         default: state_d = SSCD_IDLE;
      endcase
      oe_d = (state_d == SSCD_FRAME) && !bit_d;
   end

   // registers; the pin reset acts like the system reset
   always_ff @(posedge clock) begin
      if (any_rst) begin
         state_q <= SSCD_IDLE;
         cnt_q   <= 6'd0;
         shift_q <= 16'h0000;
         cmd_q   <= 16'h0000;
         addr_q  <= 7'h00;
         dir_q   <= 1'b0;
         inval_q <= 1'b0;
         rdata_q <= 8'h00;
         sw_q    <= SSCD_RST_SW;
         cfg_q   <= SSCD_RST_CFG;
         flags_q <= SSCD_RST_FLAGS;
         burst_q <= SSCD_RST_BURST;
         soft_q  <= SSCD_RST_SOFT;
         bit_q   <= 1'b1;
         oe_q    <= 1'b0;
         crcf_q  <= SSCD_RST_CFG[SSCD_BIT_CRC];
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         cmd_q   <= cmd_d;
         addr_q  <= addr_d;
         dir_q   <= dir_d;
         inval_q <= inval_d;
         rdata_q <= rdata_d;
         sw_q    <= sw_d;
         cfg_q   <= cfg_d;
         flags_q <= flags_d;
         burst_q <= burst_d;
         soft_q  <= soft_d;
         bit_q   <= bit_d;
         oe_q    <= oe_d;
         crcf_q  <= crcf_d;
      end
   end

   // outputs straight from flops; the pin only ever pulls low
   always_ff @(posedge clock) begin
      if (srst) begin
         sdo_o     <= 1'b0;
         sdo_oe    <= 1'b0;
         switch_en <= 4'h0;
         err_flag  <= 3'h0;
      end else begin
         sdo_o     <= 1'b0;
         sdo_oe    <= oe_q;
         switch_en <= sw_q[3:0];
         err_flag  <= flags_q[2:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (any_rst);

   align_first_a: assert property (cs_fall ##1 1 |-> ##1 oe_q == !SSCD_ALIGN[7])
      else $error("alignment msb not driven at frame start");
   addr_latch_a: assert property (at_addr |=> addr_q == $past(byte_now[6:0]))
      else $error("address not taken at eighth edge");
   plain_write_a: assert property (at_base && !crc_en && !dir_q && !inval_q &&
         addr_q == SSCD_ADDR_SW |=> sw_q == ($past(byte_now) & SSCD_MASK_SW))
      else $error("write not committed at sixteenth edge");
   sw_change_a: assert property ($changed(sw_q) |->
         $past(cnt_q) == SSCD_CNT_BASE - 6'd1 || $past(cnt_q) == SSCD_CNT_CRC - 6'd1)
      else $error("switch data changed outside a commit edge");
   crc_bad_a: assert property (at_crc && crc_en && !dir_q && !crc_ok
         |=> flags_q[SSCD_BIT_CRC] && $stable(sw_q))
      else $error("bad crc did not block and flag");
   sclk_count_a: assert property (cs_rise && state_q == SSCD_FRAME && cfg_q[SSCD_BIT_SCLK] &&
         cnt_q != (crcf_q ? SSCD_CNT_CRC : SSCD_CNT_BASE) |=> flags_q[SSCD_BIT_SCLK])
      else $error("clock count error not flagged");
   rw_flag_a: assert property (at_check && cfg_q[SSCD_BIT_RW] && !dir_q &&
         addr_q == SSCD_ADDR_FLAGS |=> inval_q ##1 flags_q[SSCD_BIT_RW])
      else $error("write to read-only register not flagged");
   idle_release_a: assert property (state_q == SSCD_IDLE |-> !oe_q)
      else $error("sdo pulled low outside a frame");
   cfg_default_a: assert property ($past(any_rst) && !any_rst |->
         cfg_q == SSCD_RST_CFG && sw_q == SSCD_RST_SW)
      else $error("configuration not at defaults after reset");
endmodule : sscd_top

// ### testbench/sscd_host_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// spi master in the host's place: 8 clocks per sclk cycle, 4 low then 4 high
module sscd_host_model (
   input  wire logic clock,
   input  wire logic sdo_line,
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi
);
   // idle pins before the first frame
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one framed transfer of n cycles; sdo is read just before the next fall,
   // where the previous bit is still standing
   task automatic frame(input logic [23:0] tx, input int n, input bit m3,
                        output logic [23:0] rx);
      rx = '0;
      @(posedge clock);
      sclk <= m3; // idle level picks the mode
      @(posedge clock);
      cs_n <= 1'b0; // held low for the whole frame
      repeat (8) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b0;
         sdi  <= tx[23 - i]; // msb first, n cycles per frame
         repeat (4) @(posedge clock);
         sclk <= 1'b1; // device samples sdi on this rise
         repeat (3) @(posedge clock);
         @(negedge clock);
         rx[23 - i] = sdo_line;
         @(posedge clock);
      end
      sclk <= m3;
      repeat (4) @(posedge clock);
      cs_n <= 1'b1;
      sdi  <= ~sdi; // released data line does not keep its last value
      repeat (10) @(posedge clock);
   endtask : frame
endmodule : sscd_host_model

// ### testbench/testbench.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
module testbench;
   import sscd_pkg::*;
   logic        clock, srst, rst_pin_n, sclk, cs_n, sdi, sdo_o, sdo_oe, sdo_line;
   logic [3:0]  switch_en;
   logic [2:0]  err_flag;
   logic [23:0] rx;
   logic [15:0] rnd;
   bit          crc_on;
   int          errors, checks_done;
   // open-drain wire with pull-up
   assign sdo_line = sdo_oe ? sdo_o : 1'b1;
   sscd_top u_sscd_top (.clock(clock), .srst(srst), .rst_pin_n(rst_pin_n),
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
      .switch_en(switch_en), .err_flag(err_flag));
   sscd_host_model u_sscd_host_model (.clock(clock), .sdo_line(sdo_line),
      .sclk(sclk), .cs_n(cs_n), .sdi(sdi));
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   // crc8 x^8+x^2+x+1, seed zero, msb first
   function automatic logic [7:0] crc8(input logic [15:0] p);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ p[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction : lfsr
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   // n of zero means the nominal length; crcx spoils the crc byte
   task automatic xfer(input logic dir, input logic [6:0] addr, input logic [7:0] data,
                       input int n, input bit m3, input logic [7:0] crcx);
      int len;
      len = (n != 0) ? n : (crc_on ? 24 : 16);
      u_sscd_host_model.frame({dir, addr, data, crc8({dir, addr, data}) ^ crcx}, len, m3, rx);
   endtask : xfer
   task automatic clear_flags();
      xfer(1'b0, 7'h6C, 8'hA9, 0, 1'b0, 8'h00);
      check("err_flag clear", err_flag, 3'b000);
   endtask : clear_flags
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      srst = 1'b1;
      rst_pin_n = 1'b1;
      rnd = 16'h0B41;
      repeat (5) @(posedge clock);
      srst <= 1'b0;
      repeat (6) @(posedge clock);
      check("switch_en", switch_en, 4'h0);
      xfer(1'b1, SSCD_ADDR_CFG, 8'hFF, 0, 1'b0, 8'h00);
      check("align", rx[23:16], 8'h25);
      check("cfg reset", rx[15:8], 8'h06);
      // random writes in both modes, each read back with spoiled input data
      for (int k = 0; k < 6; k++) begin
         rnd = lfsr(rnd);
         xfer(1'b0, SSCD_ADDR_SW, rnd[7:0], 0, k[0], 8'h00);
         check("switch_en", switch_en, rnd[3:0]);
         xfer(1'b1, SSCD_ADDR_SW, ~rnd[7:0], 0, 1'b0, 8'h00);
         check("sw read", rx[15:8], {4'h0, rnd[3:0]});
         check("switch_en", switch_en, rnd[3:0]);
      end
      // short frame writes nothing, long frame writes and flags
      xfer(1'b0, SSCD_ADDR_SW, {4'h0, ~rnd[3:0]}, 12, 1'b0, 8'h00);
      check("switch_en", switch_en, rnd[3:0]);
      check("err_flag", err_flag, 3'b010);
      clear_flags();
      xfer(1'b0, SSCD_ADDR_SW, 8'h09, 20, 1'b0, 8'h00);
      check("switch_en", switch_en, 4'h9);
      check("err_flag", err_flag, 3'b010);
      clear_flags();
      // stored-only registers keep their writable bits, read back in mode 3
      xfer(1'b0, SSCD_ADDR_BURST, 8'hFF, 0, 1'b1, 8'h00);
      xfer(1'b1, SSCD_ADDR_BURST, 8'h00, 0, 1'b1, 8'h00);
      check("burst read", rx[15:8], SSCD_MASK_BURST);
      xfer(1'b0, SSCD_ADDR_SOFT, rnd[15:8], 0, 1'b0, 8'h00);
      xfer(1'b1, SSCD_ADDR_SOFT, 8'h00, 0, 1'b1, 8'h00);
      check("soft read", rx[15:8], rnd[15:8]);
      // missing and read-only targets
      foreach (rx[i]) if (i < 3) begin
         xfer(1'b0, (i == 0) ? 7'h10 : (i == 1) ? SSCD_ADDR_FLAGS : 7'h7F, 8'h06, 0, 1'b0, 8'h00);
         check("switch_en", switch_en, 4'h9);
         check("err_flag", err_flag, 3'b100);
         xfer(1'b1, SSCD_ADDR_FLAGS, 8'h00, 0, 1'b0, 8'h00);
         check("flags read", rx[15:8], 8'h04);
         clear_flags();
      end
      // crc on: good write, bad write, read crc, short frame
      xfer(1'b0, SSCD_ADDR_CFG, 8'h07, 0, 1'b0, 8'h00);
      crc_on = 1'b1;
      xfer(1'b0, SSCD_ADDR_SW, 8'h03, 0, 1'b1, 8'h00);
      check("switch_en", switch_en, 4'h3);
      check("err_flag", err_flag, 3'b000);
      xfer(1'b0, SSCD_ADDR_SW, 8'h0C, 0, 1'b0, 8'h01);
      check("switch_en", switch_en, 4'h3);
      check("err_flag", err_flag, 3'b001);
      clear_flags();
      xfer(1'b1, SSCD_ADDR_SW, 8'h00, 0, 1'b0, 8'h00);
      check("read crc", rx[7:0], crc8({1'b1, SSCD_ADDR_SW, 8'h03}));
      xfer(1'b0, SSCD_ADDR_SW, 8'h0C, 16, 1'b0, 8'h00);
      check("switch_en", switch_en, 4'h3);
      check("err_flag", err_flag, 3'b010);
      clear_flags();
      // all detection off: nothing is flagged
      xfer(1'b0, SSCD_ADDR_CFG, 8'h00, 0, 1'b0, 8'h00);
      crc_on = 1'b0;
      xfer(1'b0, 7'h10, 8'h00, 0, 1'b0, 8'h00);
      xfer(1'b0, SSCD_ADDR_SW, 8'h00, 12, 1'b0, 8'h00);
      check("err_flag", err_flag, 3'b000);
      check("switch_en", switch_en, 4'h3);
      // reset pin opens the switches and restores defaults
      rst_pin_n <= 1'b0;
      repeat (6) @(posedge clock);
      rst_pin_n <= 1'b1;
      repeat (8) @(posedge clock);
      check("switch_en", switch_en, 4'h0);
      xfer(1'b1, SSCD_ADDR_CFG, 8'h00, 0, 1'b0, 8'h00);
      check("cfg reset", rx[15:8], 8'h06);
      summarize();
   end
endmodule : testbench
